/* File: verilog/btsd_defs.vh */
// Purpose: Shared constants for the bit test and skip decoder.
// Assumes: Included by bare name from the design files.
// Notes:   Every opcode, field position, limit and phase code lives here.
`ifndef BTSD_DEFS_VH
`define BTSD_DEFS_VH

// Opcode prefix for the skip when clear form.
`define BTSD_OP_TEST_CLEAR   4'hB
// Opcode prefix for the skip when set form.
`define BTSD_OP_TEST_SET     4'hA

// Field positions inside the 16-bit instruction word.
`define BTSD_OP_HI           15
`define BTSD_OP_LO           12
`define BTSD_BIT_HI          11
`define BTSD_BIT_LO          9
`define BTSD_ACC_POS         8
`define BTSD_FILE_HI         7
`define BTSD_FILE_LO         0

// Highest file address handled by indexed literal offset addressing.
`define BTSD_INDEX_LIMIT     8'h5F
// First file address that maps to the upper half of the shared bank.
`define BTSD_ACC_SPLIT       8'h60
// Bank number used for the upper half of the shared bank.
`define BTSD_ACC_HIGH_BANK   4'hF
// Bank number used for the lower half of the shared bank.
`define BTSD_ACC_LOW_BANK    4'h0

// Quadrature phase codes, one clock each.
`define BTSD_Q1              2'h0
`define BTSD_Q2              2'h1
`define BTSD_Q3              2'h2
`define BTSD_Q4              2'h3

// Controller state codes.
`define BTSD_ST_IDLE         2'h0
`define BTSD_ST_TEST         2'h1
`define BTSD_ST_SKIP         2'h2

// Word counts of the following instruction.
`define BTSD_WORDS_ONE       2'h1
`define BTSD_WORDS_THREE     2'h3

`endif

/* File: verilog/btsd_addr_form.v */
// Purpose: Forms the data memory address of the tested file register.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   Shared bank, banked and indexed literal offset forms are covered.
`timescale 1ns/1ns
`include "btsd_defs.vh"

module btsd_addr_form #(
	parameter BANK_W = 4,
	parameter AW     = 12
) (
	// Operand fields of the instruction.
	input  wire [7:0]        file_addr,
	input  wire              access_sel,
	// Core state that steers the address.
	input  wire              ext_set_en,
	input  wire [BANK_W-1:0] bank_pointer_register,
	input  wire [AW-1:0]     index_base,
	// Formed address.
	output reg  [AW-1:0]     data_addr,
	output reg               indexed
);

	// Selects one of the three addressing forms.
	always @*
	begin
		indexed   = 1'b0;
		data_addr = {AW{1'b0}};
		if (access_sel)
		begin
			// Banked access through the bank pointer.
			data_addr = {bank_pointer_register, file_addr};
		end
		else if (ext_set_en && (file_addr <= `BTSD_INDEX_LIMIT))
		begin
			// Indexed literal offset from the index base.
			indexed   = 1'b1;
			data_addr = index_base + {{(AW-8){1'b0}}, file_addr};
		end
		else if (file_addr < `BTSD_ACC_SPLIT)
		begin
			// Lower half of the shared bank.
			data_addr = {`BTSD_ACC_LOW_BANK, file_addr};
		end
		else
		begin
			// Upper half of the shared bank.
			data_addr = {`BTSD_ACC_HIGH_BANK, file_addr};
		end
	end

endmodule

/* File: verilog/btsd_decoder.v */
// Purpose: Decode and cycle control of the two bit test and skip instructions.
// Assumes: One clock per quadrature phase, four clocks per instruction cycle.
// Notes:   The fetch unit offers a word at Q1 and the word count of the next one.
//
// What this block does
// - Prefix 1011 selects bit test skip clear.
// - Prefix 1010 selects bit test skip set.
// - Clear form skips when bit is zero.
// - Set form skips when bit is one.
// - Skip discards prefetch, costs two cycles.
// - Two-word skip three cycles, three-word four.
// - Extra cycles idle; first cycle reads, evaluates.
// - Access bit picks shared or pointer bank.
// - Extended set indexes addresses up to 5Fh.
`timescale 1ns/1ns
`include "btsd_defs.vh"

module btsd_decoder #(
	parameter BANK_W = 4,
	parameter AW     = 12
) (
	// Clock and reset.
	input  wire              clk,
	input  wire              nrst,
	// Fetch side.
	input  wire [15:0]       instr_word,
	input  wire              instr_valid,
	input  wire [1:0]        next_words,
	// Core configuration.
	input  wire              ext_set_en,
	input  wire [BANK_W-1:0] bank_pointer_register,
	input  wire [AW-1:0]     index_base,
	// Data memory path.
	output wire [AW-1:0]     data_addr,
	output wire              data_rd,
	input  wire [7:0]        data_rdata,
	// Execution status.
	output wire [1:0]        q_phase,
	output wire              busy,
	output wire              nop_cycle,
	output wire              discard_prefetch,
	output wire              instr_done,
	output wire              skip_taken,
	output wire              indexed_mode,
	// Write enables that this block never raises.
	output wire              file_we,
	output wire              status_we
);

	reg  [1:0]    q_r;            // Current quadrature phase.
	reg  [1:0]    state_r;        // Controller state.
	reg  [1:0]    state_nxt;      // Next controller state.
	reg  [15:0]   word_r;         // Latched instruction word.
	reg           kind_set_r;     // High for the skip when set form.
	reg           skip_r;         // Result of the bit evaluation.
	reg  [1:0]    extra_r;        // Inserted cycles still to run.
	reg  [AW-1:0] addr_r;         // Registered data address.
	reg           rd_r;           // Read strobe during Q2.
	reg           indexed_r;      // Indexed form in use.
	reg           discard_r;      // Prefetch discard pulse.
	reg           done_r;         // Instruction finished pulse.
	wire [1:0]    op_words;       // Sanitised count of skipped words.
	wire          hit_clear;      // Word is the skip when clear form.
	wire          hit_set;        // Word is the skip when set form.
	wire [AW-1:0] formed_addr_now;    // Address formed from the offered word.
	wire          formed_indexed_now; // Indexed flag for the offered word.
	wire [2:0]    bit_idx;        // Index of the tested bit.
	wire          tested_bit;     // Value of the tested bit.

	// Opcode recognition on the offered word.
	assign hit_clear = (instr_word[`BTSD_OP_HI:`BTSD_OP_LO] == `BTSD_OP_TEST_CLEAR);
	assign hit_set   = (instr_word[`BTSD_OP_HI:`BTSD_OP_LO] == `BTSD_OP_TEST_SET);

	// Bit selection from the returned data byte.
	assign bit_idx    = word_r[`BTSD_BIT_HI:`BTSD_BIT_LO];
	assign tested_bit = data_rdata[bit_idx];

	// A zero word count is treated as a single word; counts of one to three pass through.
	assign op_words = (next_words == 2'h0) ? `BTSD_WORDS_ONE : next_words;

	// Phase counter runs freely; each instruction cycle spans Q1 to Q4.
	always @(posedge clk)
	begin
		if (!nrst)
			q_r <= `BTSD_Q1;
		else
			q_r <= q_r + 2'h1;
	end

	// Next state: a test starts at Q1, each cycle ends at Q4.
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			`BTSD_ST_IDLE:
			begin
				// Accept a recognised word only at the start of a cycle.
				if ((q_r == `BTSD_Q1) && instr_valid && (hit_clear || hit_set))
					state_nxt = `BTSD_ST_TEST;
			end
			`BTSD_ST_TEST:
			begin
				// The decision falls at Q4 of the test cycle.
				if (q_r == `BTSD_Q4)
					state_nxt = skip_r ? `BTSD_ST_SKIP : `BTSD_ST_IDLE;
			end
			`BTSD_ST_SKIP:
			begin
				// Leave after the last inserted cycle.
				if ((q_r == `BTSD_Q4) && (extra_r == `BTSD_WORDS_ONE))
					state_nxt = `BTSD_ST_IDLE;
			end
			default:
			begin
				state_nxt = `BTSD_ST_IDLE;
			end
		endcase
	end

	// State register.
	always @(posedge clk)
	begin
		if (!nrst)
			state_r <= `BTSD_ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Latch the instruction during its decode phase.
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			word_r     <= 16'h0000;
			kind_set_r <= 1'b0;
		end
		else if ((state_r == `BTSD_ST_IDLE) && (state_nxt == `BTSD_ST_TEST))
		begin
			word_r     <= instr_word;
			kind_set_r <= hit_set;
		end
	end

	// Read at Q2, evaluate at Q3, only in the first cycle of the test.
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			addr_r    <= {AW{1'b0}};
			rd_r      <= 1'b0;
			indexed_r <= 1'b0;
			skip_r    <= 1'b0;
		end
		else
		begin
			// The strobe lasts exactly the Q2 clock.
			rd_r <= (state_nxt == `BTSD_ST_TEST) && (q_r == `BTSD_Q1);
			if ((state_nxt == `BTSD_ST_TEST) && (q_r == `BTSD_Q1))
			begin
				// Address is formed from the offered word, not from word_r, which is latched on this same edge.
				addr_r    <= formed_addr_now;
				indexed_r <= formed_indexed_now;
			end
			if ((state_r == `BTSD_ST_TEST) && (q_r == `BTSD_Q3))
			begin
				// Clear form skips on zero, set form skips on one.
				if (kind_set_r)
					skip_r <= tested_bit;
				else
					skip_r <= ~tested_bit;
			end
			else if (state_r == `BTSD_ST_IDLE)
				skip_r <= 1'b0;
		end
	end

	// The word is latched on the Q1 edge, so the address is formed from the input.
	btsd_addr_form #(
		.BANK_W (BANK_W),
		.AW     (AW)
	) u_addr_now (
		.file_addr             (instr_word[`BTSD_FILE_HI:`BTSD_FILE_LO]),
		.access_sel            (instr_word[`BTSD_ACC_POS]),
		.ext_set_en            (ext_set_en),
		.bank_pointer_register (bank_pointer_register),
		.index_base            (index_base),
		.data_addr             (formed_addr_now),
		.indexed               (formed_indexed_now)
	);

	// Inserted cycle counter and end of instruction pulses.
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			extra_r   <= 2'h0;
			discard_r <= 1'b0;
			done_r    <= 1'b0;
		end
		else
		begin
			discard_r <= 1'b0;
			done_r    <= 1'b0;
			if ((state_r == `BTSD_ST_TEST) && (q_r == `BTSD_Q4))
			begin
				// One inserted cycle per word of the skipped instruction.
				extra_r   <= skip_r ? op_words : 2'h0;
				discard_r <= skip_r;
				done_r    <= ~skip_r;
			end
			else if ((state_r == `BTSD_ST_SKIP) && (q_r == `BTSD_Q4))
			begin
				// Inserted cycles perform nothing but count down.
				extra_r <= extra_r - 2'h1;
				done_r  <= (extra_r == `BTSD_WORDS_ONE);
			end
		end
	end

	// Status outputs.
	assign q_phase          = q_r;
	assign busy             = (state_r != `BTSD_ST_IDLE);
	assign nop_cycle        = (state_r == `BTSD_ST_SKIP);
	assign discard_prefetch = discard_r;
	assign instr_done       = done_r;
	assign skip_taken       = skip_r && (state_r != `BTSD_ST_IDLE);
	assign indexed_mode     = indexed_r;
	assign data_addr        = addr_r;
	assign data_rd          = rd_r;

	// Testing never writes the file register or any status flag.
	assign file_we   = 1'b0;
	assign status_we = 1'b0;

endmodule

/* File: verilog/unused.v */
`timescale 1ns/1ns

/* File: tb/btsd_chk_sva.sv */
// Purpose: Timing checks on the bit test decoder ports.
// Assumes: One clock per quadrature phase.
// Notes:   Helper state tracks the test in flight.
`timescale 1ns/1ns

module btsd_chk (
	// Clock and reset.
	input wire        clk,
	input wire        nrst,
	// Fetch side.
	input wire [15:0] instr_word,
	input wire        instr_valid,
	input wire [1:0]  next_words,
	// Data path and status.
	input wire [7:0]  data_rdata,
	input wire        data_rd,
	input wire [1:0]  q_phase,
	input wire        busy,
	input wire        nop_cycle,
	input wire        discard_prefetch,
	input wire        instr_done,
	input wire        file_we,
	input wire        status_we
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	reg [15:0] word_r;  // Word of the test in flight.
	reg        skip_r;  // Expected skip decision.
	reg        cut_r;   // A skip is being served.
	reg [1:0]  nw_r;    // Words of the skipped instruction.
	reg [4:0]  nop_r;   // No-op clocks counted so far.
	wire       tst = busy && !nop_cycle;  // Inside the test cycle.
	wire       bv = data_rdata[word_r[11:9]];  // Tested bit.
	// Accepted bit test word at Q1.
	sequence s_take;
		q_phase == 2'h0 && instr_valid && !busy &&
		(instr_word[15:12] == 4'hB || instr_word[15:12] == 4'hA);
	endsequence
	// Last phase of the test cycle.
	sequence s_q4;
		q_phase == 2'h3 && tst;
	endsequence
	// Follows each test to predict decision and length.
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			cut_r <= 1'b0;
			nop_r <= 5'h00;
		end
		else
		begin
			if (q_phase == 2'h0 && !busy)
				word_r <= instr_word;
			if (q_phase == 2'h2 && tst)
				skip_r <= (word_r[15:12] == 4'hB) ? !bv : bv;
			if (q_phase == 2'h3 && tst)
				nw_r <= (next_words == 2'h0) ? 2'h1 : next_words;
			if (discard_prefetch)
				cut_r <= 1'b1;
			if (instr_done)
				cut_r <= 1'b0;
			nop_r <= instr_done ? 5'h00 : nop_r + {4'h0, nop_cycle};
		end
	end
	a_take_read_end: assert property (s_take |=> data_rd ##3 (instr_done || discard_prefetch))
		else $error("bit test did not read in Q2 and end after four clocks");
	a_read_in_q2: assert property (data_rd |-> q_phase == 2'h1 ##1 !data_rd)
		else $error("read strobe outside a single Q2 clock");
	a_skip_decide: assert property (s_q4 |=> discard_prefetch == skip_r && instr_done == !skip_r)
		else $error("skip decision does not match tested bit");
	a_nop_count: assert property (instr_done |-> nop_r == (cut_r ? {1'b0, nw_r, 2'b00} : 5'h00))
		else $error("wrong number of no-op clocks");
	a_nop_quiet: assert property (nop_cycle |-> busy && !data_rd && !instr_done)
		else $error("activity during a no-op cycle");
	a_discard_once: assert property (discard_prefetch |-> nop_cycle ##1 !discard_prefetch)
		else $error("discard not a single pulse into a no-op");
	a_done_pulse: assert property (instr_done |=> !instr_done && !nop_cycle)
		else $error("completion pulse too long");
	a_no_writes: assert property (!file_we && !status_we)
		else $error("write enable raised");
endmodule

bind btsd_decoder btsd_chk u_chk (.clk, .nrst, .instr_word, .instr_valid, .next_words,
	.data_rdata, .data_rd, .q_phase, .busy, .nop_cycle, .discard_prefetch, .instr_done,
	.file_we, .status_we);

/* File: tb/btsd_mem.sv */
// Purpose: Data memory stand-in answering file reads.
// Assumes: Read strobe lasts one clock.
// Notes:   The bus toggles between reads so stale data never looks valid.
`timescale 1ns/1ns

module btsd_mem (
	// Clock and read request.
	input  wire       clk,
	input  wire       data_rd,
	// Byte placed at the read address.
	input  wire [7:0] fill,
	// Read data.
	output reg  [7:0] data_rdata
);
	initial data_rdata = 8'h5A;
	// Answer one clock after the strobe, else scramble.
	always @(posedge clk)
	begin
		if (data_rd)
			data_rdata <= fill;
		else
			data_rdata <= ~data_rdata;
	end
endmodule

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the bit test decoder.
// Assumes: Inputs change at the falling edge.
// Notes:   Each scenario is its own task.
`timescale 1ns/1ns

module tb;
	reg         clk = 1'b0;    // Core clock.
	reg         nrst = 1'b0;   // Reset, active low.
	reg  [15:0] instr_word = 16'h0000;
	reg         instr_valid = 1'b0;
	reg  [1:0]  next_words = 2'h1;
	reg         ext_set_en = 1'b0;
	reg  [3:0]  bank_pointer_register = 4'h5;
	reg  [11:0] index_base = 12'h200;
	reg  [7:0]  fill = 8'h00;  // Byte the memory returns.
	wire [11:0] data_addr;
	wire [7:0]  data_rdata;
	wire [1:0]  q_phase;
	wire        data_rd, busy, nop_cycle, discard_prefetch, instr_done;
	wire        skip_taken, indexed_mode, file_we, status_we;
	integer     num_errors = 0;
	integer     cmp_count = 0;
	integer     i;

	btsd_decoder DUT (.clk, .nrst, .instr_word, .instr_valid, .next_words, .ext_set_en,
		.bank_pointer_register, .index_base, .data_addr, .data_rd, .data_rdata, .q_phase,
		.busy, .nop_cycle, .discard_prefetch, .instr_done, .skip_taken, .indexed_mode,
		.file_we, .status_we);
	btsd_mem u_mem (.clk, .data_rd, .fill, .data_rdata);

	initial
	begin
		forever #5 clk = ~clk;
	end

	// Counts a compare and reports a difference.
	task chk(input [15:0] seen, input [15:0] exp, input [8*12:1] what);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("MISMATCH %0s exp %h seen %h", what, exp, seen);
		end
	end
	endtask

	// Prints counts and verdict, then stops.
	task report_and_stop;
	begin
		$display("Errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask

	// One bit test: checks address, decision and length.
	task bt(input [3:0] op, input [2:0] b, input a, input [7:0] f,
		input [1:0] nw, input [7:0] v, input [11:0] ea);
		reg     sk;
		integer n;
		integer d;
	begin
		while (q_phase !== 2'h0 || busy !== 1'b0)
			@(negedge clk);
		sk = (op == 4'hB) ? !v[b] : v[b];
		instr_word = {op, b, a, f};
		instr_valid = 1'b1;
		fill = v;
		next_words = nw;
		@(negedge clk);
		instr_valid = 1'b0;
		chk(data_rd, 1, "read strobe");
		chk(data_addr, ea, "address");
		n = 1;
		d = 0;
		while (instr_done !== 1'b1 && n < 40)
		begin
			d = d + discard_prefetch;
			if (n == 3)
				chk(skip_taken, sk, "skip taken");
			if (n == 4)
				chk(nop_cycle, sk, "nop cycle");
			@(negedge clk);
			n = n + 1;
		end
		chk(d, sk, "discard");
		chk(n, sk ? 4 + 4 * ((nw == 2'h0) ? 1 : nw) : 4, "clocks");
	end
	endtask

	// Both forms on every bit index, bit set and clear.
	task sc_forms;
	begin
		for (i = 0; i < 8; i = i + 1)
		begin
			bt(4'hB, i[2:0], 1, 8'h21, 1, 8'h01 << i, 12'h521);
			bt(4'hB, i[2:0], 1, 8'h21, 1, ~(8'h01 << i), 12'h521);
			bt(4'hA, i[2:0], 1, 8'h21, 1, 8'h01 << i, 12'h521);
			bt(4'hA, i[2:0], 1, 8'h21, 1, ~(8'h01 << i), 12'h521);
		end
	end
	endtask

	// Skips over one, two and three word followers.
	task sc_words;
	begin
		for (i = 0; i < 4; i = i + 1)
			bt(4'hA, 3'h3, 1, 8'h40, i[1:0], 8'hFF, 12'h540);
	end
	endtask

	// Shared bank halves, pointer bank and indexed form.
	task sc_addr;
	begin
		bt(4'hB, 3'h0, 0, 8'h10, 1, 8'h01, 12'h010);
		bt(4'hB, 3'h0, 0, 8'h80, 1, 8'h01, 12'hF80);
		ext_set_en = 1'b1;
		bt(4'hB, 3'h0, 0, 8'h5F, 1, 8'h01, 12'h25F);
		chk(indexed_mode, 1, "indexed");
		bt(4'hB, 3'h0, 0, 8'h60, 1, 8'h01, 12'hF60);
		chk(indexed_mode, 0, "indexed");
		bt(4'hB, 3'h0, 1, 8'h10, 1, 8'h01, 12'h510);
		ext_set_en = 1'b0;
	end
	endtask

	// A foreign opcode at Q1 must start nothing.
	task sc_refuse;
	begin
		while (q_phase !== 2'h0 || busy !== 1'b0)
			@(negedge clk);
		instr_word = 16'h8321;
		instr_valid = 1'b1;
		@(negedge clk);
		instr_valid = 1'b0;
		repeat (3)
		begin
			chk(data_rd, 0, "refused rd");
			chk(busy, 0, "refused busy");
			@(negedge clk);
		end
		// A bit test word offered outside Q1 is ignored as well.
		while (q_phase !== 2'h1 || busy !== 1'b0)
			@(negedge clk);
		instr_word = 16'hB321;
		instr_valid = 1'b1;
		@(negedge clk);
		instr_valid = 1'b0;
		repeat (4)
		begin
			chk(busy, 0, "late busy");
			@(negedge clk);
		end
	end
	endtask

	// Main sequence after ten clocks of reset.
	initial
	begin
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		sc_forms;
		sc_words;
		sc_addr;
		sc_refuse;
		report_and_stop;
	end

	// About 280 clocks are needed; cut off far beyond that.
	initial
	begin
		#50000;
		num_errors = num_errors + 1;
		report_and_stop;
	end
endmodule
